// ### wwd_pkg.sv
// shared constants and types for the windowed watchdog register block
package wwd_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STAT = 3'h1;
  localparam logic [2:0] IDX_IRQ = 3'h2;
  localparam logic [2:0] IDX_MASK = 3'h3;
  localparam logic [2:0] IDX_KEY = 3'h4;
  // field positions
  localparam int WIN_HI = 7;
  localparam int WIN_LO = 4;
  localparam int PER_HI = 3;
  localparam int PER_LO = 0;
  localparam int LOCK_BIT = 7;
  localparam int SYNC_BIT = 0;
  localparam int IRQ_TO = 0;
  localparam int IRQ_EARLY = 1;
  localparam int IRQ_SYNC = 2;
  localparam int IRQ_W = 3;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  // period codes and counts in watchdog clock ticks
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam logic [13:0] LIM_BASE = 14'h0008;
  localparam logic [13:0] LIM_MAX = 14'h2000;
  // ticks of the watchdog clock for a control transfer
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  // clk_sys cycles the unlock key stays open (four instructions)
  localparam logic [2:0] UNLOCK_CYC = 3'h4;
  // clk_sys cycles after reset release before the fuse is loaded
  localparam logic [1:0] BOOT_CYC = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // counter phases, gray along off, normal, closed, open
  typedef enum logic [1:0] {
    WWD_OFF = 2'b00,
    WWD_NORM = 2'b01,
    WWD_CLOSED = 2'b11,
    WWD_OPEN = 2'b10
  } wwd_state_t;

  // ticks selected by a period code; reserved codes act as the longest
  function automatic logic [13:0] wwd_limit(input logic [3:0] code);
    if (code == CODE_OFF || code > CODE_MAX) begin
      return LIM_MAX;
    end
    return LIM_BASE << (code - 4'h1);
  endfunction : wwd_limit
endpackage : wwd_pkg

// ### wwd_regs.sv
// windowed watchdog: axi4-lite registers, lock, sync and counter
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module wwd_regs
  import wwd_pkg::*;
#(
  parameter int AW = 8,
  parameter logic [7:0] UNLOCK_KEY = 8'hC3 // arbitrary key value
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watchdog_counter_clock,
  input wire logic restart_command,
  input wire logic debug_mode,
  input wire logic [7:0] watchdog_config_fuse,
  output logic system_reset_req,
  output logic irq
);

  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [AW-1:0] aw_addr_q;
  logic [7:0] w_data_q, rdata_q;
  logic w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] ctrl_q, ctl_act_q, fuse_s1_q, fuse_s2_q;
  logic lock_q, sync_q, rst_pend_q, sysrst_q;
  logic [1:0] sync_cnt_q, boot_cnt_q;
  logic [2:0] key_cnt_q;
  logic [IRQ_W-1:0] irq_flag_q, irq_mask_q, irq_set;
  logic osc_s1_q, osc_s2_q, osc_s3_q, dbg_s1_q, dbg_s2_q;
  logic [13:0] cnt_q, cnt_d;
  wwd_state_t state_q, state_d;
  logic to_fire, early_fire;

  // address decode, shared by both directions
  wire [2:0] wr_idx = aw_addr_q[4:2];
  wire [2:0] rd_idx = s_axi_araddr[4:2];
  wire wr_hit = (aw_addr_q[AW-1:5] == '0) && (wr_idx <= IDX_KEY);
  wire rd_hit = (s_axi_araddr[AW-1:5] == '0) && (rd_idx <= IDX_KEY);
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_do = wr_fire & wr_hit & w_strb_q;
  wire ar_fire = s_axi_arvalid & ~rvalid_q;
  wire key_open = (key_cnt_q != 3'h0);
  wire boot_load = (boot_cnt_q == BOOT_CYC); // both fuse stages filled
  wire boot_done = (boot_cnt_q == BOOT_CYC + 2'h1);

  // protected writes; a write during sync is dropped, not queued
  wire wr_ctrl_ok = wr_do && wr_idx == IDX_CTRL && key_open
    && !lock_q && !sync_q && boot_done;
  wire lock_set = wr_do && wr_idx == IDX_STAT && key_open
    && w_data_q[LOCK_BIT];
  wire lock_clr = wr_do && wr_idx == IDX_STAT && key_open
    && dbg_s2_q && !w_data_q[LOCK_BIT];
  wire fuse_lock = boot_load
    && fuse_s2_q[PER_HI:PER_LO] != CODE_OFF;
  wire key_wr = wr_do && wr_idx == IDX_KEY && w_data_q == UNLOCK_KEY;

  // watchdog tick: edge of the second synchroniser stage only
  wire tick = osc_s2_q & ~osc_s3_q;
  wire sync_done = sync_q && tick && sync_cnt_q == SYNC_TICKS - 2'h1;

  // active fields and their tick counts
  wire [3:0] per = ctl_act_q[PER_HI:PER_LO];
  wire [3:0] win = ctl_act_q[WIN_HI:WIN_LO];
  wire enabled = (per != CODE_OFF);
  wire windowed = (win != CODE_OFF);
  wire [13:0] per_last = wwd_limit(per) - 14'h0001;
  wire [13:0] win_last = wwd_limit(win) - 14'h0001;

  // read mux; unused bits read as zero
  wire [7:0] stat_rd = {lock_q, 6'h00, sync_q};
  wire [7:0] rd_mux =
    rd_idx == IDX_CTRL ? ctrl_q :
    rd_idx == IDX_STAT ? stat_rd :
    rd_idx == IDX_IRQ ? {5'h00, irq_flag_q} :
    rd_idx == IDX_MASK ? {5'h00, irq_mask_q} : 8'h00;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h00_0000, rdata_q};
  assign system_reset_req = sysrst_q;
  assign irq = |(irq_flag_q & irq_mask_q);
  assign irq_set = {sync_done, early_fire, to_fire};

  // write channels are caught in either order, then answered
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read answer registered on the same edge that takes the address
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // synchronisers for pins from outside this clock
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      dbg_s1_q <= 1'b0;
      dbg_s2_q <= 1'b0;
      fuse_s1_q <= 8'h00;
      fuse_s2_q <= 8'h00;
    end else begin
      osc_s1_q <= watchdog_counter_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      dbg_s1_q <= debug_mode;
      dbg_s2_q <= dbg_s1_q;
      fuse_s1_q <= watchdog_config_fuse;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  // boot load, unlock key window and lock bit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boot_cnt_q <= 2'h0;
      key_cnt_q <= 3'h0;
      ctrl_q <= CTRL_RST;
      lock_q <= STAT_RST[LOCK_BIT];
    end else begin
      if (!boot_done) begin
        boot_cnt_q <= boot_cnt_q + 2'h1;
      end
      if (key_wr) begin
        key_cnt_q <= UNLOCK_CYC;
      end else if (key_open) begin
        key_cnt_q <= key_cnt_q - 3'h1;
      end
      if (boot_load) begin
        ctrl_q <= fuse_s2_q;
      end else if (wr_ctrl_ok) begin
        ctrl_q <= w_data_q;
      end
      if (fuse_lock || lock_set) begin
        lock_q <= 1'b1;
      end else if (lock_clr) begin
        lock_q <= 1'b0;
      end
    end
  end

  // control transfer into the tick domain; fuse value goes straight in
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= STAT_RST[SYNC_BIT];
      sync_cnt_q <= 2'h0;
      ctl_act_q <= CTRL_RST;
    end else if (boot_load) begin
      ctl_act_q <= fuse_s2_q;
    end else if (wr_ctrl_ok) begin
      sync_q <= 1'b1;
      sync_cnt_q <= 2'h0;
    end else if (sync_done) begin
      sync_q <= 1'b0;
      ctl_act_q <= ctrl_q;
    end else if (sync_q && tick) begin
      sync_cnt_q <= sync_cnt_q + 2'h1;
    end
  end

  // counter phases, stepped once per watchdog tick; the debug halt acts every clk_sys cycle
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    to_fire = 1'b0;
    early_fire = 1'b0;
    if (dbg_s2_q) begin
      // halted: counter cleared, first window after debug is plain
      cnt_d = 14'h0000;
      state_d = enabled ? WWD_NORM : WWD_OFF;
    end else if (tick) begin
      if (!enabled) begin
        state_d = WWD_OFF;
        cnt_d = 14'h0000;
      end else begin
        cnt_d = cnt_q + 14'h0001;
        case (state_q)
          WWD_OFF: begin
            state_d = WWD_NORM;
            cnt_d = 14'h0000;
          end
          WWD_NORM: begin
            if (rst_pend_q) begin
              cnt_d = 14'h0000;
              state_d = windowed ? WWD_CLOSED : WWD_NORM;
            end else if (cnt_q >= per_last) begin
              to_fire = 1'b1;
              cnt_d = 14'h0000;
            end
          end
          WWD_CLOSED: begin
            if (rst_pend_q) begin
              early_fire = 1'b1;
              cnt_d = 14'h0000;
              state_d = WWD_NORM;
            end else if (!windowed) begin
              state_d = WWD_NORM;
              cnt_d = 14'h0000;
            end else if (cnt_q >= win_last) begin
              state_d = WWD_OPEN;
              cnt_d = 14'h0000;
            end
          end
          WWD_OPEN: begin
            if (rst_pend_q) begin
              cnt_d = 14'h0000;
              state_d = windowed ? WWD_CLOSED : WWD_NORM;
            end else if (cnt_q >= per_last) begin
              to_fire = 1'b1;
              cnt_d = 14'h0000;
              state_d = WWD_NORM;
            end
          end
          default: begin
            state_d = WWD_OFF;
            cnt_d = 14'h0000;
          end
        endcase
      end
    end
  end

  // counter state, restart hold-over and reset pulse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= WWD_OFF;
      cnt_q <= 14'h0000;
      rst_pend_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      // a restart is held until a tick consumes it; a new one wins
      rst_pend_q <= restart_command | (rst_pend_q & ~tick);
      sysrst_q <= to_fire | early_fire;
    end
  end

  // sticky event flags; a set in the clear cycle wins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_flag_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
    end else begin
      if (wr_do && wr_idx == IDX_IRQ) begin
        irq_flag_q <= (irq_flag_q & ~w_data_q[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_flag_q <= irq_flag_q | irq_set;
      end
      if (wr_do && wr_idx == IDX_MASK) begin
        irq_mask_q <= w_data_q[IRQ_W-1:0];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_restart_tick;
    tick && rst_pend_q && !dbg_s2_q && enabled;
  endsequence
  sequence s_ctrl_try;
    wr_do && wr_idx == IDX_CTRL && boot_done;
  endsequence

  property p_win_enter;
    s_restart_tick ##0 (state_q == WWD_NORM && windowed)
      |=> state_q == WWD_CLOSED;
  endproperty
  a_win_enter: assert property (p_win_enter)
    else $error("restart with window set did not close the window");

  property p_closed_len;
    tick && !dbg_s2_q && enabled && windowed && state_q == WWD_CLOSED
      && !rst_pend_q && cnt_q == win_last |=> state_q == WWD_OPEN;
  endproperty
  a_closed_len: assert property (p_closed_len)
    else $error("closed window did not end at its length");

  property p_off;
    tick && !dbg_s2_q && per == CODE_OFF |=> state_q == WWD_OFF;
  endproperty
  a_off: assert property (p_off)
    else $error("watchdog runs with zero time-out field");

  property p_locked;
    s_ctrl_try ##0 lock_q |=> $stable(ctrl_q) ##1 $stable(ctrl_q);
  endproperty
  a_locked: assert property (p_locked)
    else $error("control changed while locked");

  property p_lock_sticky;
    lock_q && !dbg_s2_q |=> lock_q;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock cleared outside debug");

  property p_boot_lock;
    fuse_lock |=> lock_q && ctrl_q == $past(fuse_s2_q);
  endproperty
  a_boot_lock: assert property (p_boot_lock)
    else $error("fuse load did not set control and lock");

  property p_key;
    s_ctrl_try ##0 !key_open |=> $stable(ctrl_q);
  endproperty
  a_key: assert property (p_key)
    else $error("control written without unlock key");

  property p_sync_set;
    wr_ctrl_ok |=> sync_q [*2];
  endproperty
  a_sync_set: assert property (p_sync_set)
    else $error("sync pending not raised by control write");

  property p_sync_clr;
    sync_done |=> !sync_q && ctl_act_q == ctrl_q;
  endproperty
  a_sync_clr: assert property (p_sync_clr)
    else $error("sync pending not cleared after transfer");

  property p_restart;
    s_restart_tick ##0 state_q == WWD_NORM |=> cnt_q == 14'h0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear the counter");

  property p_early;
    s_restart_tick ##0 state_q == WWD_CLOSED |=> system_reset_req;
  endproperty
  a_early: assert property (p_early)
    else $error("restart in closed window gave no reset");

endmodule : wwd_regs
`default_nettype wire

// ### wwd_core_model.sv
// core model: turns a bench request into a one-cycle restart pulse
`timescale 1ns/100ps
`default_nettype none
module wwd_core_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic kick,
  output logic restart_command
);
  // one restart instruction gives one pulse; silent during reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      restart_command <= 1'b0;
    end else begin
      restart_command <= kick;
    end
  end
endmodule : wwd_core_model
`default_nettype wire

// ### tb.sv
// bench for the watchdog register block with a small reference model
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wwd_pkg::*;
  localparam logic [7:0] KEY_VAL = 8'hC3; // arbitrary key value
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, fuse = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, kick = 1'b0, debug_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, restart_command;
  logic system_reset_req, irq;
  logic [1:0] bresp, rresp, wresp, rsp;
  logic [31:0] rdata, rdat;
  logic [2:0] oc = 3'h0;
  wire logic osc;
  bit m_lock = 1'b0;
  logic [7:0] m_ctrl = 8'h0;
  int n_rst = 0;
  int mismatches = 0;
  int n_compared = 0;

  // oscillator at one eighth of clk_sys, four high and four low
  always @(posedge clk_sys) oc <= oc + 3'h1;
  assign osc = oc[2];
  always #12.5 clk_sys = ~clk_sys;
  // count system reset pulses seen
  always @(posedge clk_sys) if (system_reset_req === 1'b1) n_rst <= n_rst + 1;

  wwd_regs #(.AW(8), .UNLOCK_KEY(KEY_VAL)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .watchdog_counter_clock(osc), .restart_command(restart_command),
    .debug_mode(debug_mode), .watchdog_config_fuse(fuse),
    .system_reset_req(system_reset_req), .irq(irq)
  );
  wwd_core_model core (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .kick(kick),
    .restart_command(restart_command)
  );

  function automatic logic [7:0] adr(input logic [2:0] i);
    return {3'b000, i, 2'b00};
  endfunction : adr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // readies are sampled at the edge, valids dropped only once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b0;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wresp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    bready <= 1'b0;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdat = rdata;
    rsp = rresp;
  endtask : rd

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : pause

  task automatic restart();
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
  endtask : restart

  // poll sync pending under a bound, then compare the whole status
  task automatic wait_sync();
    int i;
    for (i = 0; i < 40; i++) begin
      rd(adr(IDX_STAT));
      if (rdat[SYNC_BIT] === 1'b0) break;
    end
    chk(rdat, {24'h0, m_lock, 7'h0});
  endtask : wait_sync

  // key then write back to back keeps the write inside the key window
  task automatic put_ctrl(input logic [7:0] d, input bit keyed);
    bit take;
    take = keyed && !m_lock;
    if (keyed) wr(adr(IDX_KEY), KEY_VAL);
    wr(adr(IDX_CTRL), d);
    if (take) m_ctrl = d;
    rd(adr(IDX_STAT));
    chk(rdat, {24'h0, m_lock, 6'h0, take});
    wait_sync();
    rd(adr(IDX_CTRL));
    chk(rdat, {24'h0, m_ctrl});
  endtask : put_ctrl

  task automatic put_stat(input logic [7:0] d, input bit keyed);
    if (keyed) wr(adr(IDX_KEY), KEY_VAL);
    wr(adr(IDX_STAT), d);
    if (keyed && d[LOCK_BIT]) m_lock = 1'b1;
    if (keyed && !d[LOCK_BIT] && debug_mode) m_lock = 1'b0;
    rd(adr(IDX_STAT));
    chk(rdat, {24'h0, m_lock, 7'h0});
  endtask : put_stat

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // hang guard, far beyond the planned run
  initial begin
    #(25 * 40000);
    mismatches++;
    test_done();
  end

  initial begin
    int base;
    int gap;
    void'($urandom(67));
    pause(8);
    sys_rst <= 1'b0;
    pause(3);
    rd(adr(IDX_CTRL));
    chk(rdat, 32'h0);
    rd(adr(IDX_STAT));
    chk(rdat, 32'h0);
    rd(8'h1C);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h1C, 8'hFF);
    chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
    put_stat(8'h80, 1'b0);
    put_ctrl(8'h01, 1'b0);
    put_ctrl(8'h01, 1'b1);
    // sync-done event: flag, mask, clear
    rd(adr(IDX_IRQ));
    chk(rdat, 32'h4);
    wr(adr(IDX_MASK), 8'h04);
    chk({31'h0, irq}, 32'h1);
    wr(adr(IDX_IRQ), 8'h04);
    chk({31'h0, irq}, 32'h0);
    wr(adr(IDX_MASK), 8'h01);
    // plain time-out of 8 ticks after the last restart
    restart();
    pause(16);
    restart();
    base = n_rst;
    pause(46);
    chk(32'(n_rst), 32'(base));
    pause(44);
    chk(32'(n_rst), 32'(base + 1));
    chk({31'h0, irq}, 32'h1);
    rd(adr(IDX_IRQ));
    chk({31'h0, rdat[IRQ_TO]}, 32'h1);
    // random restart spacing inside the time-out keeps it quiet
    restart();
    base = n_rst;
    repeat (8) begin
      gap = 16 + int'($urandom % 24);
      pause(gap);
      restart();
    end
    chk(32'(n_rst), 32'(base));
    // windowed: closed 8 ticks, then open 8 ticks
    put_ctrl(8'h11, 1'b1);
    restart();
    pause(16);
    base = n_rst;
    repeat (3) begin
      pause(96);
      restart();
    end
    chk(32'(n_rst), 32'(base));
    pause(24);
    restart();
    pause(40);
    chk(32'(n_rst), 32'(base + 1));
    rd(adr(IDX_IRQ));
    chk({31'h0, rdat[IRQ_EARLY]}, 32'h1);
    // lock: set, guard control, clear only in debug
    put_stat(8'h80, 1'b1);
    put_ctrl(8'h00, 1'b1);
    put_stat(8'h00, 1'b1);
    debug_mode <= 1'b1;
    pause(4);
    put_stat(8'h00, 1'b1);
    debug_mode <= 1'b0;
    // second reset with a random enabled fuse
    fuse <= {4'($urandom % 12), 4'(1 + $urandom % 11)};
    sys_rst <= 1'b1;
    pause(2);
    sys_rst <= 1'b0;
    pause(3);
    m_ctrl = fuse;
    m_lock = 1'b1;
    rd(adr(IDX_CTRL));
    chk(rdat, {24'h0, m_ctrl});
    rd(adr(IDX_STAT));
    chk(rdat, 32'h80);
    test_done();
  end
endmodule : tb
`default_nettype wire
